// ==== hw/aas_sequencer.sv ====
// Sequencer for the amplified successive approximation converter
`timescale 1ns/1ps
`include "aas_params.svh"
module aas_sequencer
  import aas_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       conv_clock_range_sel,
  input  wire logic       auto_repeat_sel,
  input  wire logic       amp_enable_hi,
  input  wire logic       amp_enable_lo,
  input  wire logic       channel_one_select,
  input  wire logic       channel_zero_select,
  input  wire logic       run_set,
  input  wire logic       run_clear,
  input  wire aas_res_t   sar_value,
  input  wire logic       rd_channel,
  output logic            conversion_run,
  output logic            converter_on,
  output logic            conv_active_ch,
  output logic            amp_power_on,
  output logic            amp_settled,
  output logic            conv_end_irq,
  output logic            diff_mode,
  output aas_res_t        result_rd
);
  aas_state_e                state;
  logic [1:0]                amp_en;
  logic [1:0]                amp_prev;
  logic [1:0]                ch_latched;
  logic [`AAS_CNT_W-1:0]     settle_cnt;
  logic [`AAS_CNT_W-1:0]     conv_cnt;
  logic [`AAS_CNT_W-1:0]     conv_age;
  logic                      cur_ch;
  logic                      last_ch;
  logic                      wr_en;
  logic                      power_up;

  assign amp_en = {amp_enable_hi, amp_enable_lo};

  // Channel uses amplifier for this enable code
  function automatic logic amp_used(input logic [1:0] en, input logic ch);
    amp_used = (en == `AAS_AMP_BOTH) || (en == `AAS_AMP_DIFF) ||
               ((en == `AAS_AMP_CH1) && ch);
  endfunction

  // ***************************************
  // Amplifier power-up and settling wait
  // ***************************************
  // Code 01 is no power-up event, so channel 1 amplification shows settled at
  // once; software has to time that wait on its own
  assign power_up = (amp_prev == `AAS_AMP_DIRECT) && amp_used(amp_en, 1'b0);

  // Previous enable code
  always_ff @(posedge clk_sys) begin
    if (!resetn) amp_prev <= `AAS_AMP_DIRECT;
    else amp_prev <= amp_en;
  end

  // Settle counter restarts on each power-up event
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      settle_cnt <= '0;
    end else if (power_up) begin
      settle_cnt <= (amp_en == `AAS_AMP_DIFF) ? `AAS_CNT_W'(`AAS_WAIT_DF_CYC)
                                              : `AAS_CNT_W'(`AAS_WAIT_SE_CYC);
    end else if (amp_en == `AAS_AMP_DIRECT) begin
      settle_cnt <= '0;
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - `AAS_CNT_W'(1);
    end
  end

  assign amp_power_on = amp_used(amp_en, 1'b1);
  assign amp_settled  = amp_power_on && (settle_cnt == '0) && !power_up;
  assign diff_mode    = (amp_en == `AAS_AMP_DIFF);

  // ***************************************
  // Conversion sequencer
  // ***************************************
  // A run ends after channel 1, after a lone channel 0, or after the single
  // differential conversion; enable changes mid-run are left to software
  assign last_ch = (cur_ch == 1'b1) || !ch_latched[1] || (diff_mode);
  assign wr_en   = (state == AAS_CONV) && (conv_cnt == '0);

  // State, latched channels and timing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state      <= AAS_IDLE;
      ch_latched <= `AAS_CH_NONE;
      cur_ch     <= 1'b0;
      conv_cnt   <= '0;
    end else begin
      case (state)
        AAS_IDLE: begin
          if (run_set) begin
            ch_latched <= {channel_one_select, channel_zero_select};
            conv_cnt   <= `AAS_CNT_W'(`AAS_CONV_CYC - 1);
            if ({channel_one_select, channel_zero_select} == `AAS_CH_NONE) begin
              state <= AAS_HANG;
            end else begin
              state  <= AAS_CONV;
              cur_ch <= !channel_zero_select;
            end
          end
        end
        AAS_CONV: begin
          if (run_clear) begin
            state <= AAS_IDLE;
          end else if (conv_cnt != '0) begin
            conv_cnt <= conv_cnt - `AAS_CNT_W'(1);
          end else if (last_ch) begin
            state <= (auto_repeat_sel && !amp_power_on) ? AAS_CONV : AAS_IDLE;
            cur_ch   <= !ch_latched[0];
            conv_cnt <= `AAS_CNT_W'(`AAS_CONV_CYC - 1);
          end else begin
            cur_ch   <= 1'b1;
            conv_cnt <= `AAS_CNT_W'(`AAS_CONV_CYC - 1);
          end
        end
        // Empty selection parks here until software aborts the run
        AAS_HANG: begin
          if (run_clear) state <= AAS_IDLE;
        end
        default: state <= AAS_IDLE;
      endcase
    end
  end

  // End-of-conversion pulse
  always_ff @(posedge clk_sys) begin
    if (!resetn) conv_end_irq <= 1'b0;
    else conv_end_irq <= wr_en && last_ch && !run_clear;
  end

  // Cycles into the conversion in progress, so the checks can time each
  // conversion without trusting the down-counter that paces it
  always_ff @(posedge clk_sys) begin
    if (!resetn || (state != AAS_CONV) || wr_en) begin
      conv_age <= '0;
    end else begin
      conv_age <= conv_age + `AAS_CNT_W'(1);
    end
  end

  // Run bit is the state itself, so it falls in the cycle the interrupt rises, except in auto-repeat with the amplifier off, where the run goes on
  assign conversion_run = (state != AAS_IDLE);
  assign converter_on   = conversion_run;
  assign conv_active_ch = cur_ch;

  // Result store; differential result lands in channel 0
  aas_result_mem u_mem (
    .clk_sys (clk_sys),
    .wr_en   (wr_en && !run_clear),
    .wr_idx  (diff_mode ? 1'b0 : cur_ch),
    .wr_data (sar_value),
    .rd_idx  (rd_channel),
    .rd_data (result_rd)
  );

  // ***************************************
  // Checks
  // ***************************************
  sequence s_start_ok;
    state == AAS_IDLE && run_set && {channel_one_select, channel_zero_select} != `AAS_CH_NONE;
  endsequence

  chk_start_conv: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_start_ok |=> state == AAS_CONV)
    else $error("conversion did not start");
  chk_no_chan_hang: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AAS_HANG && !run_clear |=> state == AAS_HANG && !conv_end_irq)
    else $error("empty channel run left hang state");
  chk_irq_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_end_irq && amp_power_on |-> !conversion_run)
    else $error("run bit not cleared at end");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AAS_CONV && $past(state) == AAS_CONV |-> $stable(ch_latched))
    else $error("channel latch changed mid run");
  chk_diff_ch0: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_en && diff_mode |-> !u_mem.wr_idx)
    else $error("differential result not in channel 0");
  chk_powerup_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
    power_up |=> !amp_settled)
    else $error("settled too early after power-up");
  chk_conv_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_start_ok |=> !wr_en [*8])
    else $error("conversion finished too early");
  chk_irq_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_end_irq |-> $past(wr_en))
    else $error("interrupt without result write");

  // Conversion timing against helper state, interrupt width, first channel, write target and the hang run bit
  chk_conv_period: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_en |-> conv_age == `AAS_CNT_W'(`AAS_CONV_CYC - 1))
    else $error("conversion length differs from the set count");
  chk_irq_single: assert property (@(posedge clk_sys) disable iff (!resetn)
    conv_end_irq |=> !conv_end_irq)
    else $error("end interrupt longer than one cycle");
  chk_first_channel: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_start_ok ##0 channel_zero_select |=> !conv_active_ch)
    else $error("run did not begin at the lowest channel");
  chk_write_selected: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_en && !diff_mode |-> (cur_ch ? ch_latched[1] : ch_latched[0]))
    else $error("result written to a channel not latched at start");
  chk_hang_run_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    state == AAS_HANG |-> conversion_run && !wr_en)
    else $error("empty channel run dropped the run bit");
endmodule

// ==== hw/aas_params.svh ====
// Constants for the amplified converter sequencer
`ifndef AAS_PARAMS_SVH
`define AAS_PARAMS_SVH
`define AAS_CLK_HZ        40000000
`define AAS_CLK_MHZ       (`AAS_CLK_HZ / 1000000)
`define AAS_CONV_TIME_NS  46000
`define AAS_CONV_CYC      ((`AAS_CONV_TIME_NS * (`AAS_CLK_HZ / 1000000)) / 1000)
`define AAS_PWRUP_NS      30000
`define AAS_SETTLE_SE_NS  54000
`define AAS_SETTLE_DF_NS  64000
`define AAS_WAIT_SE_CYC   (((`AAS_PWRUP_NS + `AAS_SETTLE_SE_NS) * `AAS_CLK_MHZ + 999) / 1000)
`define AAS_WAIT_DF_CYC   (((`AAS_PWRUP_NS + `AAS_SETTLE_DF_NS) * `AAS_CLK_MHZ + 999) / 1000)
`define AAS_AMP_DIRECT    2'h0
`define AAS_AMP_CH1       2'h1
`define AAS_AMP_BOTH      2'h2
`define AAS_AMP_DIFF      2'h3
`define AAS_CH_NONE       2'h0
`define AAS_RES_W         12
`define AAS_RES_ZERO      12'h000
`define AAS_CNT_W         12
`endif

// ==== hw/aas_pkg.sv ====
// Types for the amplified converter sequencer
package aas_pkg;
  typedef enum logic [1:0] {AAS_IDLE, AAS_CONV, AAS_HANG} aas_state_e;
  typedef logic [11:0] aas_res_t;
endpackage

// ==== hw/aas_result_mem.sv ====
// Two-entry result store, registered read
`timescale 1ns/1ps
`include "aas_params.svh"
module aas_result_mem
  import aas_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     wr_en,
  input  wire logic     wr_idx,
  input  wire aas_res_t wr_data,
  input  wire logic     rd_idx,
  output aas_res_t      rd_data
);
  aas_res_t mem [2];
  // Write port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  // Registered read port
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_idx];
  end
endmodule

// ==== tb/aas_sequencer_bench.sv ====
// Self-checking bench for the amplified converter sequencer
`timescale 1ns/1ps
`include "aas_params.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module aas_sequencer_bench
  import aas_pkg::*;
;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        range_sel = 1'b1;
  logic        repeat_sel = 1'b0;
  logic [1:0]  amp_en = 2'h0;
  logic [1:0]  ch_sel = 2'h0;
  logic        run_set = 1'b0;
  logic        run_clear = 1'b0;
  aas_res_t    sar_value = 12'h000;
  logic        rd_channel = 1'b0;
  logic        conversion_run, converter_on, conv_active_ch;
  logic        amp_power_on, amp_settled, conv_end_irq, diff_mode;
  aas_res_t    result_rd;
  aas_res_t    exp_res [2];
  logic [31:0] seed = 32'h2fdf2b3f;
  int          bad_count = 0;
  int          n_compared = 0;
  int          irq_seen = 0;
  int          cyc = 0;
  int          n;
  int          gaps;

  aas_sequencer i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .conv_clock_range_sel(range_sel),
    .auto_repeat_sel(repeat_sel), .amp_enable_hi(amp_en[1]), .amp_enable_lo(amp_en[0]),
    .channel_one_select(ch_sel[1]), .channel_zero_select(ch_sel[0]), .run_set(run_set),
    .run_clear(run_clear), .sar_value(sar_value), .rd_channel(rd_channel),
    .conversion_run(conversion_run), .converter_on(converter_on),
    .conv_active_ch(conv_active_ch), .amp_power_on(amp_power_on),
    .amp_settled(amp_settled), .conv_end_irq(conv_end_irq), .diff_mode(diff_mode),
    .result_rd(result_rd));

  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // Cycle ceiling and interrupt pulse counter
  always @(posedge clk_sys) begin
    cyc++;
    if (conv_end_irq === 1'b1) irq_seen++;
    if (cyc == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  // Galois shift register for sample values
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Next random converter sample
  task automatic new_sample();
    seed = lfsr(seed);
    sar_value <= seed[11:0];
  endtask

  // Apply an enable code and time the settling wait
  task automatic settle(input logic [1:0] code, input int w);
    @(posedge clk_sys);
    amp_en <= code;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (amp_settled !== 1'b1 && n < 5000);
    `CHK("settle_time", 1'b1, (n >= w) && (n <= w + 2))
  endtask

  // Start a run of k conversions, changing inputs while it runs
  task automatic convert(input int k);
    @(posedge clk_sys);
    run_set <= 1'b1;
    n = 0;
    gaps = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n == 1 || n == 501) run_set <= 1'b0;
      if (n == 500) run_set <= 1'b1;
      if (n == 10) ch_sel <= 2'h2;
      if (n == 2000) begin
        new_sample();
        exp_res[1] = seed[11:0];
      end
      #1;
      if (conv_end_irq !== 1'b1 && conversion_run !== 1'b1) gaps++;
      if (n == 1) `CHK("first_ch", 1'b0, conv_active_ch)
      if (k > 1 && n == `AAS_CONV_CYC + 1) `CHK("second_ch", 1'b1, conv_active_ch)
    end while (conv_end_irq !== 1'b1 && n < 4000);
    `CHK("end_time", `AAS_CONV_CYC * k + 1, n)
    `CHK("run_cleared", 1'b0, conversion_run)
    `CHK("run_gaps", 0, gaps)
    @(posedge clk_sys);
    #1;
    `CHK("irq_pulse", 1'b0, conv_end_irq)
  endtask

  // Read both result slots and compare with the model
  task automatic read_all();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      rd_channel <= c[0];
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("result", exp_res[c], result_rd)
    end
  endtask

  // Report counts and verdict
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    `CHK("reset_run", 1'b0, conversion_run)
    `CHK("reset_settled", 1'b0, amp_settled)
    settle(`AAS_AMP_BOTH, `AAS_WAIT_SE_CYC);
    `CHK("diff_off", 1'b0, diff_mode)
    `CHK("amp_on", 1'b1, amp_power_on)
    @(posedge clk_sys);
    ch_sel <= 2'h3;
    new_sample();
    exp_res[0] = seed[11:0];
    convert(2);
    read_all();
    @(posedge clk_sys);
    amp_en <= `AAS_AMP_DIRECT;
    settle(`AAS_AMP_DIFF, `AAS_WAIT_DF_CYC);
    `CHK("diff_on", 1'b1, diff_mode)
    @(posedge clk_sys);
    ch_sel <= 2'h1;
    new_sample();
    exp_res[0] = seed[11:0];
    convert(1);
    read_all();
    @(posedge clk_sys);
    amp_en <= `AAS_AMP_DIRECT;
    ch_sel <= `AAS_CH_NONE;
    n = irq_seen;
    @(posedge clk_sys);
    #1;
    `CHK("amp_off", 1'b0, amp_power_on)
    @(posedge clk_sys);
    run_set <= 1'b1;
    @(posedge clk_sys);
    run_set <= 1'b0;
    repeat (4000) @(posedge clk_sys);
    #1;
    `CHK("hang_run", 1'b1, converter_on)
    `CHK("hang_irq", n, irq_seen)
    @(posedge clk_sys);
    run_clear <= 1'b1;
    @(posedge clk_sys);
    run_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("abort_run", 1'b0, conversion_run)
    read_all();
    finish_test();
  end
endmodule
